// ### ccar_calendar.sv
// module: calendar counters with load, carry and leap-year handling
`timescale 1ns/100ps
module ccar_calendar (
	// clock and reset
	input wire logic clock_i,
	input wire logic rst_n_i,
	// control
	input wire logic tick_i,
	input wire logic load_i,
	input wire logic leap_suppress_i,
	input wire ccar_pkg::ccar_cal_t set_i,
	// current calendar
	output ccar_pkg::ccar_cal_t cal_o
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	ccar_pkg::ccar_cal_t st;
	ccar_pkg::ccar_cal_t next_st;

	assign cal_o = st;

	// days in the month, leap suppressed on request
	function automatic logic [4:0] month_len(input logic [3:0] m, input logic [11:0] y,
		input logic sup);
		case (m)
			4'h2: month_len = (y[1:0] == 2'h0 && !sup) ? 5'h1D : 5'h1C;
			4'h4, 4'h6, 4'h9, 4'hB: month_len = 5'h1E;
			default: month_len = 5'h1F;
		endcase
	endfunction : month_len

	// counting with carry
	always_comb begin
		next_st = st;
		if (load_i) begin
			next_st = set_i;
		end else if (tick_i) begin
			if (st.tod.sec >= ccar_pkg::SEC_MAX) begin
				next_st.tod.sec = '0;
				if (st.tod.min >= ccar_pkg::MIN_MAX) begin
					next_st.tod.min = '0;
					if (st.tod.hour >= ccar_pkg::HOUR_MAX) begin
						next_st.tod.hour = '0;
						next_st.tod.dotw = (st.tod.dotw >= ccar_pkg::DOTW_MAX) ? 3'h0
							: st.tod.dotw + 3'h1;
						if (st.date.day >= month_len(st.date.month, st.date.year,
							leap_suppress_i)) begin
							next_st.date.day = 5'h01;
							if (st.date.month >= ccar_pkg::MONTH_MAX) begin
								next_st.date.month = 4'h1;
								next_st.date.year = st.date.year + 12'h001;
							end else begin
								next_st.date.month = st.date.month + 4'h1;
							end
						end else begin
							next_st.date.day = st.date.day + 5'h01;
						end
					end else begin
						next_st.tod.hour = st.tod.hour + 5'h01;
					end
				end else begin
					next_st.tod.min = st.tod.min + 6'h01;
				end
			end else begin
				next_st.tod.sec = st.tod.sec + 6'h01;
			end
		end
	end

	// register
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st <= '{date: ccar_pkg::DATE_RST, tod: ccar_pkg::TIME_RST};
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_feb_no_leap;
		@(posedge clock_i) disable iff (!rst_n_i)
		(tick_i && !load_i && leap_suppress_i && st.date.month == ccar_pkg::MONTH_FEB
			&& st.date.day == 5'h1C && st.tod.hour == ccar_pkg::HOUR_MAX
			&& st.tod.min == ccar_pkg::MIN_MAX && st.tod.sec == ccar_pkg::SEC_MAX)
			|=> st.date.day == 5'h01;
	endproperty
	a_feb_no_leap: assert property (p_feb_no_leap) else $error("february ran past 28");

	property p_sec_wrap;
		@(posedge clock_i) disable iff (!rst_n_i)
		(tick_i && !load_i && st.tod.sec == ccar_pkg::SEC_MAX) |=> st.tod.sec == 6'h00
			&& st.tod.min != $past(st.tod.min);
	endproperty
	a_sec_wrap: assert property (p_sec_wrap) else $error("seconds did not carry");

endmodule : ccar_calendar

// ### ccar_pkg.sv
// package: register map, field layouts and calendar types of the calendar clock
package ccar_pkg;

	// ----------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] ADDR_DIV = 8'h00;
	localparam logic [7:0] ADDR_DATE_SETUP = 8'h04;
	localparam logic [7:0] ADDR_TIME_SETUP = 8'h08;
	localparam logic [7:0] ADDR_CTRL = 8'h0C;
	localparam logic [7:0] ADDR_DATE_ALARM = 8'h10;
	localparam logic [7:0] ADDR_TIME_ALARM = 8'h14;
	localparam logic [7:0] ADDR_CUR_DATE = 8'h18;
	localparam logic [7:0] ADDR_CUR_TIME = 8'h1C;
	localparam logic [7:0] ADDR_IRQ_RAW = 8'h20;
	localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h24;
	localparam logic [7:0] ADDR_IRQ_FORCE = 8'h28;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h2C;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_ACTIVE_BIT = 1;
	localparam int CTRL_LOAD_BIT = 4;
	localparam int CTRL_LEAP_BIT = 8;
	localparam int ALARM_GLOB_BIT = 28;
	localparam int ALARM_ARMED_BIT = 29;
	localparam int DATE_EN_LSB = 24;
	localparam int TIME_EN_LSB = 28;

	// ----------------------------------------
	// widths, limits and reset values
	// ----------------------------------------
	localparam int DIV_W = 16;
	localparam logic [15:0] DIV_RST = 16'h0000;
	localparam logic [5:0] SEC_MAX = 6'h3B;
	localparam logic [5:0] MIN_MAX = 6'h3B;
	localparam logic [4:0] HOUR_MAX = 5'h17;
	localparam logic [2:0] DOTW_MAX = 3'h6;
	localparam logic [3:0] MONTH_MAX = 4'hC;
	localparam logic [3:0] MONTH_FEB = 4'h2;

	// ----------------------------------------
	// calendar types
	// ----------------------------------------
	typedef struct packed {
		logic [11:0] year;
		logic [3:0] month;
		logic [4:0] day;
	} ccar_date_t;

	typedef struct packed {
		logic [2:0] dotw;
		logic [4:0] hour;
		logic [5:0] min;
		logic [5:0] sec;
	} ccar_time_t;

	typedef struct packed {
		ccar_date_t date;
		ccar_time_t tod;
	} ccar_cal_t;

	localparam ccar_date_t DATE_RST = '{year: 12'h000, month: 4'h1, day: 5'h01};
	localparam ccar_time_t TIME_RST = '{dotw: 3'h0, hour: 5'h00, min: 6'h00, sec: 6'h00};

	// date fields into their register word
	function automatic logic [31:0] pack_date(input ccar_date_t d);
		return {8'h00, d.year, d.month, 3'h0, d.day};
	endfunction : pack_date

	// time fields into their register word
	function automatic logic [31:0] pack_time(input ccar_time_t t);
		return {5'h00, t.dotw, 3'h0, t.hour, 2'h0, t.min, 2'h0, t.sec};
	endfunction : pack_time

	// register word into date fields
	function automatic ccar_date_t unpack_date(input logic [31:0] w);
		return '{year: w[23:12], month: w[11:8], day: w[4:0]};
	endfunction : unpack_date

	// register word into time fields
	function automatic ccar_time_t unpack_time(input logic [31:0] w);
		return '{dotw: w[26:24], hour: w[20:16], min: w[13:8], sec: w[5:0]};
	endfunction : unpack_time

endpackage : ccar_pkg

// ### ccar_regs.sv
// module: calendar clock register file, alarm comparator and interrupt
//
// Strobed register access was decided locally.
`timescale 1ns/100ps
module ccar_regs #(
	parameter int DIV_W = ccar_pkg::DIV_W
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic rst_n_i,
	// register port
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	// interrupt
	output logic irq_o
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic [DIV_W-1:0] div;          // second_divider
		ccar_pkg::ccar_date_t set_d;    // date_setup
		ccar_pkg::ccar_time_t set_t;    // time_setup
		logic en;                       // clock enable
		logic leap;                     // leap_suppress
		logic running;                  // clock actually running
		logic load;                     // one-cycle load pulse
		ccar_pkg::ccar_date_t al_d;     // alarm date
		ccar_pkg::ccar_time_t al_t;     // alarm time
		logic [2:0] al_den;             // year, month, day compare enables
		logic [3:0] al_ten;             // weekday, hour, minute, second enables
		logic al_glob;                  // alarm_global_enable
		logic armed;                    // match active
		ccar_pkg::ccar_date_t latch;    // date captured by a time read
		logic match_q;                  // match seen last cycle
		logic raw;                      // irq_raw
		logic inte;                     // irq_enable
		logic irq_force;                     // irq_force
		logic [31:0] rdata;             // read data
	} ccar_st_t;

	ccar_st_t st;
	ccar_st_t next_st;

	// ----------------------------------------
	// datapath wires
	// ----------------------------------------
	logic tick;                  // one-second tick
	ccar_pkg::ccar_cal_t cur;    // running calendar
	logic match;                 // enabled fields all equal
	logic match_evt;             // rising match
	logic masked;                // irq masked status

	// one-second divider
	ccar_tick #(
		.DIV_W(DIV_W)
	) u_tick (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.run_i(st.running),
		.div_i(st.div),
		.tick_o(tick)
	);

	// calendar counters
	ccar_calendar u_cal (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.tick_i(tick),
		.load_i(st.load),
		.leap_suppress_i(st.leap),
		.set_i('{date: st.set_d, tod: st.set_t}),
		.cal_o(cur)
	);

	// ----------------------------------------
	// alarm comparator
	// ----------------------------------------
	// every enabled field equal, only while globally enabled and armed
	always_comb begin
		match = st.al_glob && st.armed;
		if (st.al_den[2] && cur.date.year != st.al_d.year) match = 1'b0;
		if (st.al_den[1] && cur.date.month != st.al_d.month) match = 1'b0;
		if (st.al_den[0] && cur.date.day != st.al_d.day) match = 1'b0;
		if (st.al_ten[3] && cur.tod.dotw != st.al_t.dotw) match = 1'b0;
		if (st.al_ten[2] && cur.tod.hour != st.al_t.hour) match = 1'b0;
		if (st.al_ten[1] && cur.tod.min != st.al_t.min) match = 1'b0;
		if (st.al_ten[0] && cur.tod.sec != st.al_t.sec) match = 1'b0;
	end

	// each fresh match is an event, so partial compares repeat
	assign match_evt = match && !st.match_q;

	// masked status and the interrupt line
	assign masked = (st.raw && st.inte) || st.irq_force;
	assign irq_o = masked;
	assign rdata_o = st.rdata;

	// ----------------------------------------
	// register access and control
	// ----------------------------------------
	always_comb begin
		next_st = st;
		// running follows enable one cycle later
		next_st.running = st.en;
		// armed follows global alarm enable
		next_st.armed = st.al_glob;
		next_st.match_q = match;
		// load lasts one cycle
		next_st.load = 1'b0;
		next_st.rdata = 32'h0000_0000;

		// writes
		if (wr_i) begin
			case (addr_i)
				ccar_pkg::ADDR_DIV: begin
					next_st.div = wdata_i[DIV_W-1:0];
				end
				ccar_pkg::ADDR_DATE_SETUP: begin
					next_st.set_d = ccar_pkg::unpack_date(wdata_i);
				end
				ccar_pkg::ADDR_TIME_SETUP: begin
					next_st.set_t = ccar_pkg::unpack_time(wdata_i);
				end
				ccar_pkg::ADDR_CTRL: begin
					next_st.en = wdata_i[ccar_pkg::CTRL_EN_BIT];
					next_st.load = wdata_i[ccar_pkg::CTRL_LOAD_BIT];
					next_st.leap = wdata_i[ccar_pkg::CTRL_LEAP_BIT];
				end
				ccar_pkg::ADDR_DATE_ALARM: begin
					next_st.al_d = ccar_pkg::unpack_date(wdata_i);
					next_st.al_den = wdata_i[ccar_pkg::DATE_EN_LSB +: 3];
					next_st.al_glob = wdata_i[ccar_pkg::ALARM_GLOB_BIT];
				end
				ccar_pkg::ADDR_TIME_ALARM: begin
					next_st.al_t = ccar_pkg::unpack_time(wdata_i);
					next_st.al_ten = wdata_i[ccar_pkg::TIME_EN_LSB +: 4];
				end
				ccar_pkg::ADDR_IRQ_RAW: begin
					// write one to clear
					if (wdata_i[0]) next_st.raw = 1'b0;
				end
				ccar_pkg::ADDR_IRQ_ENABLE: begin
					next_st.inte = wdata_i[0];
				end
				ccar_pkg::ADDR_IRQ_FORCE: begin
					next_st.irq_force = wdata_i[0];
				end
				default: begin
					// unmapped or read-only: ignored
				end
			endcase
		end

		// alarm event sets raw; set wins over a same-cycle clear
		if (match_evt) next_st.raw = 1'b1;

		// reads, answered next cycle
		if (rd_i) begin
			case (addr_i)
				ccar_pkg::ADDR_DIV: begin
					next_st.rdata = {{(32 - DIV_W){1'b0}}, st.div};
				end
				ccar_pkg::ADDR_DATE_SETUP: begin
					next_st.rdata = ccar_pkg::pack_date(st.set_d);
				end
				ccar_pkg::ADDR_TIME_SETUP: begin
					next_st.rdata = ccar_pkg::pack_time(st.set_t);
				end
				ccar_pkg::ADDR_CTRL: begin
					next_st.rdata[ccar_pkg::CTRL_EN_BIT] = st.en;
					next_st.rdata[ccar_pkg::CTRL_ACTIVE_BIT] = st.running;
					next_st.rdata[ccar_pkg::CTRL_LEAP_BIT] = st.leap;
				end
				ccar_pkg::ADDR_DATE_ALARM: begin
					next_st.rdata = ccar_pkg::pack_date(st.al_d);
					next_st.rdata[ccar_pkg::DATE_EN_LSB +: 3] = st.al_den;
					next_st.rdata[ccar_pkg::ALARM_GLOB_BIT] = st.al_glob;
					next_st.rdata[ccar_pkg::ALARM_ARMED_BIT] = st.armed;
				end
				ccar_pkg::ADDR_TIME_ALARM: begin
					next_st.rdata = ccar_pkg::pack_time(st.al_t);
					next_st.rdata[ccar_pkg::TIME_EN_LSB +: 4] = st.al_ten;
				end
				ccar_pkg::ADDR_CUR_DATE: begin
					next_st.rdata = ccar_pkg::pack_date(st.latch);
				end
				ccar_pkg::ADDR_CUR_TIME: begin
					next_st.rdata = ccar_pkg::pack_time(cur.tod);
					// capture date alongside the time
					next_st.latch = cur.date;
				end
				ccar_pkg::ADDR_IRQ_RAW: begin
					next_st.rdata[0] = st.raw;
				end
				ccar_pkg::ADDR_IRQ_ENABLE: begin
					next_st.rdata[0] = st.inte;
				end
				ccar_pkg::ADDR_IRQ_FORCE: begin
					next_st.rdata[0] = st.irq_force;
				end
				ccar_pkg::ADDR_IRQ_STATUS: begin
					next_st.rdata[0] = masked;
				end
				default: begin
					next_st.rdata = 32'h0000_0000;
				end
			endcase
		end
	end

	// register all state
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st <= '0;
			st.div <= ccar_pkg::DIV_RST;
			st.latch <= ccar_pkg::DATE_RST;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!rst_n_i);

	// active bit lags enable one cycle
	property p_running;
		##1 st.running == $past(st.en);
	endproperty
	a_running: assert property (p_running) else $error("active bit not following enable");

	// no match without the global enable
	property p_glob_gate;
		!st.al_glob |-> !match;
	endproperty
	a_glob_gate: assert property (p_glob_gate) else $error("match while alarm disabled");

	property p_year_cmp;
		(match && st.al_den[2]) |-> cur.date.year == st.al_d.year;
	endproperty
	a_year_cmp: assert property (p_year_cmp) else $error("year mismatch matched");

	property p_sec_cmp;
		(match && st.al_ten[0]) |-> cur.tod.sec == st.al_t.sec;
	endproperty
	a_sec_cmp: assert property (p_sec_cmp) else $error("second mismatch matched");

	// masked status read back
	property p_status_read;
		(rd_i && addr_i == ccar_pkg::ADDR_IRQ_STATUS)
			|=> rdata_o[0] == (($past(st.raw) && $past(st.inte)) || $past(st.irq_force));
	endproperty
	a_status_read: assert property (p_status_read) else $error("masked status wrong");

	property p_raw_set;
		match_evt |=> st.raw && (irq_o || !st.inte);
	endproperty
	a_raw_set: assert property (p_raw_set) else $error("alarm event lost");

	// time read captures the date
	property p_latch;
		(rd_i && addr_i == ccar_pkg::ADDR_CUR_TIME) |=> st.latch == $past(cur.date);
	endproperty
	a_latch: assert property (p_latch) else $error("date not captured on time read");

	// load reaches the counters two cycles on
	property p_load;
		(wr_i && addr_i == ccar_pkg::ADDR_CTRL && wdata_i[ccar_pkg::CTRL_LOAD_BIT])
			|-> ##2 cur == $past({st.set_d, st.set_t}, 1);
	endproperty
	a_load: assert property (p_load) else $error("load did not copy setup");

	// disarm follows a cleared enable
	property p_armed;
		$fell(st.al_glob) |=> !st.armed ##1 !match;
	endproperty
	a_armed: assert property (p_armed) else $error("armed bit not following enable");

	property p_date_read;
		(rd_i && addr_i == ccar_pkg::ADDR_DATE_SETUP) |=> rdata_o[23:12] == $past(st.set_d.year);
	endproperty
	a_date_read: assert property (p_date_read) else $error("date setup year misplaced");

	// arm follows a set enable
	property p_armed_rise;
		$rose(st.al_glob) |=> st.armed;
	endproperty
	a_armed_rise: assert property (p_armed_rise) else $error("armed bit not set");

	// a clear with no event drops the raw flag
	property p_raw_clear;
		(wr_i && addr_i == ccar_pkg::ADDR_IRQ_RAW && wdata_i[0] && !match_evt) |=> !st.raw;
	endproperty
	a_raw_clear: assert property (p_raw_clear) else $error("raw flag not cleared");

	// force alone raises the line
	property p_force_line;
		st.irq_force |-> irq_o;
	endproperty
	a_force_line: assert property (p_force_line) else $error("force did not raise line");

	// load strobe lasts one cycle unless written again
	property p_load_pulse;
		(st.load && !(wr_i && addr_i == ccar_pkg::ADDR_CTRL
			&& wdata_i[ccar_pkg::CTRL_LOAD_BIT])) |=> !st.load;
	endproperty
	a_load_pulse: assert property (p_load_pulse) else $error("load strobe stuck");

	// time read places the seconds low
	property p_time_read;
		(rd_i && addr_i == ccar_pkg::ADDR_CUR_TIME) |=> rdata_o[5:0] == $past(cur.tod.sec);
	endproperty
	a_time_read: assert property (p_time_read) else $error("time seconds misplaced");

	c_alarm: cover property (match_evt ##1 irq_o);
	c_raw_clear: cover property (wr_i && addr_i == ccar_pkg::ADDR_IRQ_RAW && st.raw);
	c_leap_carry: cover property (tick && st.leap && cur.date.day == 5'h1C
		&& cur.date.month == ccar_pkg::MONTH_FEB);
	c_load_running: cover property (st.load && st.running);
	c_time_then_date: cover property ((rd_i && addr_i == ccar_pkg::ADDR_CUR_TIME)
		##1 (rd_i && addr_i == ccar_pkg::ADDR_CUR_DATE));

endmodule : ccar_regs

// ### ccar_tb.sv
// testbench: register-level checks of the calendar clock with alarm and interrupt
`timescale 1ns/100ps
module tb;

	// ----------------------------------------
	// signals and bench state
	// ----------------------------------------
	logic clock_i;
	logic rst_n_i;
	logic [7:0] addr_i;
	logic [31:0] wdata_i;
	logic wr_i;
	logic rd_i;
	logic [31:0] rdata_o;
	logic irq_o;
	int errors = 0;
	int checked = 0;
	int cyc = 0;
	integer seed = 32'h5C72;
	logic [31:0] v;
	// reset-value table: address and expected word
	logic [7:0] ra [13] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h1C, 8'h18, 8'h20,
		8'h24, 8'h28, 8'h2C, 8'h30};
	logic [31:0] rx [13] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h101, 32'h0,
		32'h0, 32'h0, 32'h0, 32'h0};
	// alarm table: date alarm word, time alarm word, expected raw flag
	logic [31:0] ad [7] = '{32'h0000_5307, 32'h1400_5307, 32'h1400_6307, 32'h1300_5307,
		32'h1000_0000, 32'h1000_0000, 32'h1000_0000};
	logic [31:0] at [7] = '{32'h1000_000C, 32'h1000_000C, 32'h1000_000C, 32'hF200_000C,
		32'h9300_000C, 32'h5001_000C, 32'h1000_000C};
	logic ae [7] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};

	// ----------------------------------------
	// design under test
	// ----------------------------------------
	ccar_regs #(.DIV_W(16)) dut_u (
		.clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o));

	// 200 MHz clock
	initial begin
		clock_i = 1'b0;
		forever #2.5 clock_i = ~clock_i;
	end

	// hang guard: cycle ceiling counts as a mismatch
	always @(posedge clock_i) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			errors++;
			tally_and_finish();
		end
	end

	// ----------------------------------------
	// bus tasks, compare and verdict
	// ----------------------------------------
	// one-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clock_i);
		wr_i <= 1'b0;
	endtask : wr

	// one-cycle read strobe, data taken in the following cycle
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clock_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clock_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask : rd

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic tally_and_finish();
		if (errors == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : tally_and_finish

	// ----------------------------------------
	// expectation functions
	// ----------------------------------------
	function automatic ccar_pkg::ccar_cal_t mk(input logic [11:0] y, input logic [3:0] mo,
		input logic [4:0] d, input logic [2:0] w, input logic [4:0] h, input logic [5:0] mi,
		input logic [5:0] s);
		return '{date: '{y, mo, d}, tod: '{w, h, mi, s}};
	endfunction : mk

	function automatic logic [31:0] wdate(input ccar_pkg::ccar_date_t d);
		return {8'h00, d.year, d.month, 3'h0, d.day};
	endfunction : wdate

	function automatic logic [31:0] wtime(input ccar_pkg::ccar_time_t t);
		return {5'h00, t.dotw, 3'h0, t.hour, 2'h0, t.min, 2'h0, t.sec};
	endfunction : wtime

	// calendar one second later
	function automatic ccar_pkg::ccar_cal_t bump(input ccar_pkg::ccar_cal_t c, input logic sup);
		logic [4:0] dim;
		case (c.date.month)
			4'h4, 4'h6, 4'h9, 4'hB: dim = 5'h1E;
			4'h2: dim = (c.date.year[1:0] == 2'h0 && !sup) ? 5'h1D : 5'h1C;
			default: dim = 5'h1F;
		endcase
		c.tod.sec = (c.tod.sec == 6'h3B) ? 6'h00 : c.tod.sec + 6'h01;
		if (c.tod.sec != 6'h00) return c;
		c.tod.min = (c.tod.min == 6'h3B) ? 6'h00 : c.tod.min + 6'h01;
		if (c.tod.min != 6'h00) return c;
		c.tod.hour = (c.tod.hour == 5'h17) ? 5'h00 : c.tod.hour + 5'h01;
		if (c.tod.hour != 5'h00) return c;
		c.tod.dotw = (c.tod.dotw == 3'h6) ? 3'h0 : c.tod.dotw + 3'h1;
		c.date.day = (c.date.day == dim) ? 5'h01 : c.date.day + 5'h01;
		if (c.date.day != 5'h01) return c;
		c.date.month = (c.date.month == 4'hC) ? 4'h1 : c.date.month + 4'h1;
		if (c.date.month == 4'h1) c.date.year = c.date.year + 12'h001;
		return c;
	endfunction : bump

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	// load a calendar, run two ticks, check carry, period and captured date
	task automatic run_case(input ccar_pkg::ccar_cal_t s, input logic sup, input logic [15:0] dv);
		ccar_pkg::ccar_cal_t e1;
		ccar_pkg::ccar_cal_t e2;
		logic [31:0] t;
		logic [31:0] t1;
		int n;
		e1 = bump(s, sup);
		e2 = bump(e1, sup);
		wr(ccar_pkg::ADDR_CTRL, 32'h0);
		wr(ccar_pkg::ADDR_DIV, {16'h0000, dv});
		wr(ccar_pkg::ADDR_DATE_SETUP, wdate(s.date));
		wr(ccar_pkg::ADDR_TIME_SETUP, wtime(s.tod));
		wr(ccar_pkg::ADDR_CTRL, sup ? 32'h110 : 32'h010);
		rd(ccar_pkg::ADDR_CUR_TIME, t);
		chk("loaded time", t, wtime(s.tod));
		rd(ccar_pkg::ADDR_CUR_DATE, t);
		chk("loaded date", t, wdate(s.date));
		wr(ccar_pkg::ADDR_CTRL, sup ? 32'h101 : 32'h001);
		t = wtime(s.tod);
		n = 0;
		while (t === wtime(s.tod) && n < 40) begin
			rd(ccar_pkg::ADDR_CUR_TIME, t);
			n++;
		end
		chk("time after one tick", t, wtime(e1.tod));
		t1 = t;
		n = 0;
		while (t === t1 && n < 40) begin
			rd(ccar_pkg::ADDR_CUR_TIME, t);
			n++;
		end
		chk("tick period", 32'(2 * n), {16'h0000, dv} + 32'h1);
		chk("time after two ticks", t, wtime(e2.tod));
		rd(ccar_pkg::ADDR_CUR_DATE, t);
		chk("date after two ticks", t, wdate(e2.date));
		rd(ccar_pkg::ADDR_CTRL, t);
		chk("control running", t, sup ? 32'h103 : 32'h003);
		wr(ccar_pkg::ADDR_CTRL, sup ? 32'h111 : 32'h011);
		rd(ccar_pkg::ADDR_CUR_TIME, t);
		chk("load while running", t, wtime(s.tod));
		wr(ccar_pkg::ADDR_CTRL, 32'h0);
	endtask : run_case

	// program an alarm with global enable last, run past second 12
	task automatic alarm_case(input logic [31:0] da, input logic [31:0] ta, input logic ex);
		logic [31:0] t;
		wr(ccar_pkg::ADDR_CTRL, 32'h0);
		wr(ccar_pkg::ADDR_DATE_ALARM, 32'h0);
		wr(ccar_pkg::ADDR_TIME_ALARM, ta);
		wr(ccar_pkg::ADDR_DATE_ALARM, da & 32'hEFFF_FFFF);
		wr(ccar_pkg::ADDR_DATE_ALARM, da);
		wr(ccar_pkg::ADDR_DIV, 32'h3);
		wr(ccar_pkg::ADDR_DATE_SETUP, 32'h0000_5307);
		wr(ccar_pkg::ADDR_TIME_SETUP, 32'h0200_000A);
		wr(ccar_pkg::ADDR_CTRL, 32'h010);
		wr(ccar_pkg::ADDR_IRQ_RAW, 32'h1);
		wr(ccar_pkg::ADDR_CTRL, 32'h001);
		repeat (40) @(posedge clock_i);
		wr(ccar_pkg::ADDR_CTRL, 32'h0);
		rd(ccar_pkg::ADDR_IRQ_RAW, t);
		chk("alarm raw flag", t, {31'h0, ex});
		rd(ccar_pkg::ADDR_DATE_ALARM, t);
		chk("armed flag", {31'h0, t[29]}, {31'h0, da[28]});
		rd(ccar_pkg::ADDR_TIME_ALARM, t);
		chk("time alarm word", t, ta);
	endtask : alarm_case

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		rst_n_i = 1'b0;
		addr_i = 8'h00;
		wdata_i = 32'h0;
		wr_i = 1'b0;
		rd_i = 1'b0;
		repeat (20) @(posedge clock_i);
		rst_n_i <= 1'b1;
		// writes to read-only and unmapped places are refused
		wr(ccar_pkg::ADDR_CUR_DATE, $random(seed));
		wr(ccar_pkg::ADDR_CUR_TIME, $random(seed));
		wr(ccar_pkg::ADDR_IRQ_STATUS, 32'hFFFF_FFFF);
		wr(8'h30, $random(seed));
		for (int i = 0; i < 13; i++) begin
			rd(ra[i], v);
			chk("reset value", v, rx[i]);
		end
		// divider keeps only its low half
		for (int i = 0; i < 4; i++) begin
			wr(ccar_pkg::ADDR_DIV, $random(seed));
			rd(ccar_pkg::ADDR_DIV, v);
			chk("divider readback", v, {16'h0000, wdata_i[15:0]});
		end
		// calendar corners: year end, leap, suppressed leap, short months
		run_case(mk(12'h003, 4'hC, 5'h1F, 3'h6, 5'h17, 6'h3B, 6'h3A), 1'b0, 16'h0003);
		run_case(mk(12'h004, 4'h2, 5'h1C, 3'h2, 5'h17, 6'h3B, 6'h3A), 1'b0, 16'h0005);
		run_case(mk(12'h004, 4'h2, 5'h1C, 3'h2, 5'h17, 6'h3B, 6'h3A), 1'b1, 16'h0003);
		run_case(mk(12'h004, 4'h2, 5'h1D, 3'h3, 5'h17, 6'h3B, 6'h3A), 1'b0, 16'h0003);
		run_case(mk(12'h005, 4'h4, 5'h1E, 3'h0, 5'h17, 6'h3B, 6'h3A), 1'b0, 16'h0005);
		run_case(mk(12'h005, 4'h2, 5'h1C, 3'h1, 5'h17, 6'h3B, 6'h3A), 1'b0, 16'h0003);
		// random valid calendars
		for (int i = 0; i < 6; i++) begin
			run_case(mk(12'($random(seed)), 4'($unsigned($random(seed)) % 12 + 1),
				5'($unsigned($random(seed)) % 28 + 1), 3'($unsigned($random(seed)) % 7),
				5'($unsigned($random(seed)) % 24), 6'($unsigned($random(seed)) % 60),
				6'($unsigned($random(seed)) % 60)), 1'($random(seed)), 16'h0003);
		end
		// alarm enables, global gate and partial matching
		for (int i = 0; i < 7; i++) alarm_case(ad[i], at[i], ae[i]);
		// raw flag left set: masking and forcing, then cleared
		for (int r = 1; r >= 0; r--) begin
			for (int i = 0; i < 4; i++) begin
				wr(ccar_pkg::ADDR_IRQ_ENABLE, {31'h0, i[0]});
				wr(ccar_pkg::ADDR_IRQ_FORCE, {31'h0, i[1]});
				rd(ccar_pkg::ADDR_IRQ_STATUS, v);
				chk("masked status", v, {31'h0, (r[0] & i[0]) | i[1]});
				chk("interrupt line", {31'h0, irq_o}, {31'h0, (r[0] & i[0]) | i[1]});
			end
			wr(ccar_pkg::ADDR_IRQ_RAW, 32'h1);
			rd(ccar_pkg::ADDR_IRQ_RAW, v);
			chk("raw after clear", v, 32'h0);
		end
		tally_and_finish();
	end

endmodule : tb

// ### ccar_tick.sv
// module: programmable one-second tick divider
`timescale 1ns/100ps
module ccar_tick #(
	parameter int DIV_W = 16
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic rst_n_i,
	// control
	input wire logic run_i,
	input wire logic [DIV_W-1:0] div_i,
	// tick out
	output logic tick_o
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic [DIV_W-1:0] cnt; // cycles since last tick
	} ccar_tick_st_t;

	ccar_tick_st_t st;
	ccar_tick_st_t next_st;

	// tick on the last count; >= keeps a lowered divider from running away
	assign tick_o = run_i && (st.cnt >= div_i);

	// next count
	always_comb begin
		next_st = st;
		if (!run_i) begin
			next_st.cnt = '0;
		end else if (tick_o) begin
			next_st.cnt = '0;
		end else begin
			next_st.cnt = st.cnt + 1'b1;
		end
	end

	// register
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_tick_period;
		@(posedge clock_i) disable iff (!rst_n_i)
		(run_i && !tick_o) |=> (st.cnt == $past(st.cnt) + 1'b1) || !run_i;
	endproperty
	a_tick_period: assert property (p_tick_period) else $error("tick counter skipped");

endmodule : ccar_tick
